// file: rtl/trpc_pkg.sv
// trpc_pkg: shared constants and types for the trace resource pause controller.
// assumes a single clock domain at 250 MHz with a synchronous active-high reset.
package trpc_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 4;
	// selector latency in cycles; pausing steps are timed with it
	localparam int unsigned SEL_LATENCY    = 2;
	localparam int unsigned NUM_INPUTS     = 8;
	localparam int unsigned NUM_COUNTERS   = 4;
	localparam int unsigned NUM_SEQ_STATES = 4;
	localparam int unsigned NUM_EXT_OUT    = 4;
	localparam int unsigned NUM_EVENTS     = 4;
	localparam int unsigned SYNC_WAIT      = 2;
	localparam logic        STABLE_RESET   = 1'h0;

	typedef enum logic [1:0] {
		TRPC_RUNNING,
		TRPC_PAUSING,
		TRPC_PAUSED
	} trpc_state_type;
endpackage : trpc_pkg

// file: rtl/trpc_sel_pipe.sv
// trpc_sel_pipe: fixed-latency model of the resource selector path.
// assumes the caller gates the advance enable; holding it freezes contents.
module trpc_sel_pipe #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             adv,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage_q [DEPTH];

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_q[i] <= '0;
			end
		end else if (adv) begin
			stage_q[0] <= din;
			for (int i = 1; i < DEPTH; i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign dout = stage_q[DEPTH-1];
endmodule : trpc_sel_pipe

// file: rtl/trpc_ctrl.sv
// trpc_ctrl: run, pausing and paused control of the trace filtering resources.
// assumes pin inputs arrive asynchronously and are synchronised here;
// resource inputs and instruction-block strobes come from same-clock logic.

module trpc_ctrl #(
	parameter int unsigned NIN  = trpc_pkg::NUM_INPUTS,
	parameter int unsigned NCNT = trpc_pkg::NUM_COUNTERS,
	parameter int unsigned NSEQ = trpc_pkg::NUM_SEQ_STATES,
	parameter int unsigned NOUT = trpc_pkg::NUM_EXT_OUT,
	parameter int unsigned NEV  = trpc_pkg::NUM_EVENTS
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            trace_enable,
	input  wire logic            low_power,
	input  wire logic            prohibited_region,
	input  wire logic [NIN-1:0]  resource_in,
	input  wire logic [NCNT-1:0] counter_zero,
	input  wire logic [NSEQ-1:0] seq_state,
	input  wire logic [NOUT-1:0] ext_out_req,
	input  wire logic            block_valid,
	input  wire logic            block_precise_hit,
	input  wire logic            sync_req,
	input  wire logic            cmp_busy,
	output logic [NIN-1:0]       sel_resource,
	output logic [NCNT-1:0]      sel_counter,
	output logic [NSEQ-1:0]      sel_seq,
	output logic                 resource_run,
	output logic                 counters_run,
	output logic [NOUT-1:0]      ext_out,
	output logic                 model_stable_flag,
	output logic                 paused,
	output logic                 block_result_valid,
	output logic                 block_result,
	output logic                 sync_done
);
	localparam int unsigned LAT = trpc_pkg::SEL_LATENCY;
	localparam int unsigned CW  = $clog2(2 * LAT + 1) + 1;
	localparam logic [CW-1:0] DRAIN_CYCLES = CW'(2 * LAT);

	// pin-level controls pass two flops before use
	// they reset low, so a pause walk follows every reset; the pipes start empty anyway
	logic en_s1_q, en_s2_q, lp_s1_q, lp_s2_q, pr_s1_q, pr_s2_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			en_s1_q <= 1'h0;
			en_s2_q <= 1'h0;
			lp_s1_q <= 1'h0;
			lp_s2_q <= 1'h0;
			pr_s1_q <= 1'h0;
			pr_s2_q <= 1'h0;
		end else begin
			en_s1_q <= trace_enable;
			en_s2_q <= en_s1_q;
			lp_s1_q <= low_power;
			lp_s2_q <= lp_s1_q;
			pr_s1_q <= prohibited_region;
			pr_s2_q <= pr_s1_q;
		end
	end

	function automatic logic go_ok(input logic en, input logic lp, input logic pr);
		go_ok = en && !lp && !pr;
	endfunction : go_ok

	logic                    run_ok;
	assign run_ok = go_ok(en_s2_q, lp_s2_q, pr_s2_q);

	trpc_pkg::trpc_state_type state_q, state_d;
	logic [CW-1:0]            drain_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			trpc_pkg::TRPC_RUNNING: begin
				if (!run_ok) begin
					state_d = trpc_pkg::TRPC_PAUSING;
				end
			end
			trpc_pkg::TRPC_PAUSING: begin
				// fixed drain count keeps the pausing walk bounded
				if (drain_q == DRAIN_CYCLES - CW'(1)) begin
					state_d = trpc_pkg::TRPC_PAUSED;
				end
			end
			trpc_pkg::TRPC_PAUSED: begin
				if (run_ok) begin
					state_d = trpc_pkg::TRPC_RUNNING;
				end
			end
			default: state_d = trpc_pkg::TRPC_RUNNING;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= trpc_pkg::TRPC_RUNNING;
		end else begin
			state_q <= state_d;
		end
	end

	// first LAT cycles flush forced inputs, next LAT give counters one more pass
	always_ff @(posedge clk) begin
		if (rst) begin
			drain_q <= '0;
		end else if (state_q == trpc_pkg::TRPC_PAUSING) begin
			drain_q <= drain_q + CW'(1);
		end else begin
			drain_q <= '0;
		end
	end

	logic running, pausing, is_paused;
	assign running   = (state_q == trpc_pkg::TRPC_RUNNING);
	assign pausing   = (state_q == trpc_pkg::TRPC_PAUSING);
	assign is_paused = (state_q == trpc_pkg::TRPC_PAUSED);

	// ordinary resources stop advancing once their pre-force values have drained
	logic res_adv, cnt_adv;
	assign res_adv = running || (pausing && drain_q < CW'(LAT));
	assign cnt_adv = running || pausing;

	logic [NIN-1:0] res_gated;
	assign res_gated = running ? resource_in : '0;

	trpc_sel_pipe #(.WIDTH(NIN), .DEPTH(LAT)) u_res_pipe (
		.clk  (clk),
		.rst  (rst),
		.adv  (res_adv),
		.din  (res_gated),
		.dout (sel_resource)
	);

	trpc_sel_pipe #(.WIDTH(NCNT + NSEQ), .DEPTH(LAT)) u_cnt_pipe (
		.clk  (clk),
		.rst  (rst),
		.adv  (cnt_adv),
		.din  ({counter_zero, seq_state}),
		.dout ({sel_counter, sel_seq})
	);

	// paused with tracing on: pipes hold, so in-flight events are kept
	assign resource_run = res_adv;
	assign counters_run = cnt_adv;
	assign paused       = is_paused;

	always_ff @(posedge clk) begin
		if (rst) begin
			ext_out <= '0;
		end else if (state_d == trpc_pkg::TRPC_PAUSED) begin
			ext_out <= '0;
		end else begin
			ext_out <= ext_out_req;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			model_stable_flag <= trpc_pkg::STABLE_RESET;
		end else begin
			model_stable_flag <= is_paused && !en_s2_q;
		end
	end

	// one result per block seen while running, registered so results leave in arrival order
	logic blk_v_q, blk_r_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			blk_v_q <= 1'h0;
			blk_r_q <= 1'h0;
		end else begin
			blk_v_q <= block_valid && running;
			blk_r_q <= block_precise_hit;
		end
	end
	assign block_result_valid = blk_v_q;
	assign block_result       = blk_r_q;

	// sync waits for comparators to drain earlier instructions
	// a request in the completing cycle merges into that completion
	logic sync_pend_q, sync_done_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_pend_q <= 1'h0;
			sync_done_q <= 1'h0;
		end else begin
			sync_done_q <= 1'h0;
			if (sync_pend_q && !cmp_busy) begin
				sync_pend_q <= 1'h0;
				sync_done_q <= 1'h1;
			end else if (sync_req) begin
				sync_pend_q <= 1'h1;
			end
		end
	end
	assign sync_done = sync_done_q;

	sequence pause_walk_s;
		pausing [*4] ##1 is_paused;
	endsequence

	enter_pause_a: assert property (@(posedge clk) disable iff (rst)
		running && !run_ok |=> pausing)
		else $error("running did not enter pausing");
	pause_bound_a: assert property (@(posedge clk) disable iff (rst)
		running ##1 pausing |-> pause_walk_s)
		else $error("pausing did not finish in time");
	pause_finite_a: assert property (@(posedge clk) disable iff (rst)
		pausing |-> ##[1:5] is_paused)
		else $error("pausing not bounded");
	force_low_a: assert property (@(posedge clk) disable iff (rst)
		!running |-> res_gated == '0)
		else $error("inputs not forced low");
	drain_adv_a: assert property (@(posedge clk) disable iff (rst)
		running ##1 pausing |-> res_adv [*2] ##1 !res_adv)
		else $error("pre-force values not drained");
	cnt_extra_a: assert property (@(posedge clk) disable iff (rst)
		pausing |-> cnt_adv)
		else $error("counters stopped early");
	hold_state_a: assert property (@(posedge clk) disable iff (rst)
		is_paused && $past(is_paused) |-> $stable(sel_resource) && $stable(sel_counter))
		else $error("paused resources changed");
	ext_low_a: assert property (@(posedge clk) disable iff (rst)
		is_paused |-> ext_out == '0)
		else $error("external output high while paused");
	stable_cause_a: assert property (@(posedge clk) disable iff (rst)
		model_stable_flag |-> $past(is_paused) && !$past(en_s2_q))
		else $error("stable flag set too early");
	stable_quiet_a: assert property (@(posedge clk) disable iff (rst)
		model_stable_flag |-> !res_adv && !cnt_adv && !block_result_valid)
		else $error("activity while stable");
	sync_order_a: assert property (@(posedge clk) disable iff (rst)
		sync_done |-> !$past(cmp_busy))
		else $error("sync completed while comparators busy");
	block_once_a: assert property (@(posedge clk) disable iff (rst)
		running && block_valid |=> block_result_valid)
		else $error("block not evaluated");
	block_order_a: assert property (@(posedge clk) disable iff (rst)
		block_result_valid |-> block_result == $past(block_precise_hit))
		else $error("precise result out of order");
	resume_a: assert property (@(posedge clk) disable iff (rst)
		is_paused && run_ok |=> running)
		else $error("paused did not resume");
	inflight_a: assert property (@(posedge clk) disable iff (rst)
		is_paused && en_s2_q |-> !res_adv)
		else $error("in-flight events moved while paused");
	fsm_kind_a: assert property (@(posedge clk) disable iff (rst)
		running || pausing || is_paused)
		else $error("illegal controller state");

	// pausing walk split into its two drain phases and the settled end
	sequence flush_phase_s;
		(res_adv && cnt_adv) [*2];
	endsequence

	sequence extra_phase_s;
		(!res_adv && cnt_adv) [*2];
	endsequence

	sequence settle_s;
		is_paused && !cnt_adv;
	endsequence

	pause_steps_a: assert property (@(posedge clk) disable iff (rst)
		running ##1 pausing |-> flush_phase_s ##1 extra_phase_s ##1 settle_s)
		else $error("pausing steps out of order");
	drain_cap_a: assert property (@(posedge clk) disable iff (rst)
		drain_q <= DRAIN_CYCLES)
		else $error("drain counter overran");
	pause_freeze_a: assert property (@(posedge clk) disable iff (rst)
		pausing && !res_adv |=> $stable(sel_resource))
		else $error("forced resources moved after drain");
	stable_set_a: assert property (@(posedge clk) disable iff (rst)
		is_paused && !en_s2_q |=> model_stable_flag)
		else $error("stable flag not raised");
	stable_drop_a: assert property (@(posedge clk) disable iff (rst)
		!is_paused |=> !model_stable_flag)
		else $error("stable flag high outside paused");
	ext_follow_a: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) && running && $past(running)
		|-> ext_out == $past(ext_out_req))
		else $error("external output not following request");
	block_refuse_a: assert property (@(posedge clk) disable iff (rst)
		!running |=> !block_result_valid)
		else $error("block evaluated outside running");
	sync_pulse_a: assert property (@(posedge clk) disable iff (rst)
		sync_done |=> !sync_done)
		else $error("sync done longer than one cycle");
	sync_wait_a: assert property (@(posedge clk) disable iff (rst)
		sync_pend_q && cmp_busy |=> !sync_done)
		else $error("sync done while comparators busy");
endmodule : trpc_ctrl

// file: verif/trpc_pe_model.sv
// trpc_pe_model: far-side model of the traced processor and its trace enable pins.
// assumes the bench requests at rising edges; pins and blocks follow one edge later.
module trpc_pe_model (
	input  wire logic clk,
	input  wire logic go_trace,
	input  wire logic go_sleep,
	input  wire logic go_prohib,
	input  wire logic blk_go,
	input  wire logic blk_hit,
	output logic      trace_enable,
	output logic      low_power,
	output logic      prohibited_region,
	output logic      block_valid,
	output logic      block_precise_hit
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		trace_enable      = 1'h1;
		low_power         = 1'h0;
		prohibited_region = 1'h0;
		block_valid       = 1'h0;
		block_precise_hit = 1'h0;
	end
	always @(posedge clk) begin
		trace_enable      <= go_trace;
		low_power         <= go_sleep;
		prohibited_region <= go_prohib;
		block_valid       <= blk_go;
		// outside a block the hit line toggles, so a stale value is never trusted
		block_precise_hit <= blk_go ? blk_hit : ~block_precise_hit;
	end
endmodule : trpc_pe_model

// file: verif/testbench.sv
// testbench: self-checking bench for the trace resource pause controller.
// assumes trpc_pe_model drives the pins; pins land one edge after a request.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst = 1'h1, go_trace = 1'h1, go_sleep = 1'h0, go_prohib = 1'h0;
	logic blk_go = 1'h0, blk_hit = 1'h0, sync_req = 1'h0, cmp_busy = 1'h0;
	logic te, lp, pr, bv, bh, rr, cr, flag, pz, brv, br, sd;
	logic [7:0] res_in = 8'ha5, sel_res;
	logic [3:0] cz = 4'h6, seq = 4'h3, req = 4'hf, sel_cnt, sel_sq, ext;
	int n_mismatch = 0, cmp_count = 0;
	initial forever #2 clk = ~clk;
	trpc_pe_model trpc_pe_model_i (.clk(clk), .go_trace(go_trace), .go_sleep(go_sleep),
		.go_prohib(go_prohib), .blk_go(blk_go), .blk_hit(blk_hit), .trace_enable(te),
		.low_power(lp), .prohibited_region(pr), .block_valid(bv), .block_precise_hit(bh));
	trpc_ctrl trpc_ctrl_i (.clk(clk), .rst(rst), .trace_enable(te), .low_power(lp),
		.prohibited_region(pr), .resource_in(res_in), .counter_zero(cz), .seq_state(seq),
		.ext_out_req(req), .block_valid(bv), .block_precise_hit(bh), .sync_req(sync_req),
		.cmp_busy(cmp_busy), .sel_resource(sel_res), .sel_counter(sel_cnt), .sel_seq(sel_sq),
		.resource_run(rr), .counters_run(cr), .ext_out(ext), .model_stable_flag(flag),
		.paused(pz), .block_result_valid(brv), .block_result(br), .sync_done(sd));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	// c: 0 trace disabled, 1 low power, 2 prohibited region
	task automatic pause_case(input int c);
		int n;
		logic seen;
		seen = 1'h0;
		chk("ext_out running", 4'hf, ext);
		@(posedge clk) begin
			go_trace  <= (c != 0);
			go_sleep  <= (c == 1);
			go_prohib <= (c == 2);
			res_in    <= 8'h3c;
		end
		for (n = 1; n < 20; n++) begin
			@(posedge clk);
			if (n == 5)
				cz <= 4'hc;
			#1;
			if (sel_res === 8'h3c)
				seen = 1'h1;
			if (n == 7) begin
				chk("resource_run pausing", 1'h0, rr);
				chk("counters_run pausing", 1'h1, cr);
			end
			if (pz === 1'h1)
				break;
		end
		chk("edges to paused", 8, n);
		chk("last inputs propagated", 1'h1, seen);
		chk("sel_resource paused", 8'h00, sel_res);
		chk("sel_counter paused", 4'hc, sel_cnt);
		chk("sel_seq paused", 4'h3, sel_sq);
		chk("ext_out paused", 4'h0, ext);
		@(posedge clk) begin
			cz     <= 4'h9;
			blk_go <= 1'h1;
		end
		#1;
		chk("stable flag", (c == 0), flag);
		@(posedge clk) blk_go <= 1'h0;
		repeat (3) begin
			@(posedge clk);
			#1;
			chk("block refused paused", 1'h0, brv);
			chk("sel_counter frozen", 4'hc, sel_cnt);
			chk("counters_run paused", 1'h0, cr);
		end
		@(posedge clk) begin
			go_trace  <= 1'h1;
			go_sleep  <= 1'h0;
			go_prohib <= 1'h0;
			cz        <= 4'h6;
			res_in    <= 8'ha5;
		end
		for (n = 0; n < 10 && pz !== 1'h0; n++)
			@(posedge clk) #1;
		chk("back to running", 1'h0, pz);
		repeat (4) @(posedge clk);
	endtask : pause_case
	task automatic block_case();
		for (int k = 0; k < 6; k++) begin
			@(posedge clk) begin
				blk_go  <= (k < 3);
				blk_hit <= (k != 1);
			end
			#1;
			if (k >= 2)
				chk("block result valid", (k <= 4), brv);
			if (k >= 2 && k <= 4)
				chk("block result order", (k != 3), br);
		end
	endtask : block_case
	task automatic sync_case();
		int hits;
		hits = 0;
		@(posedge clk) begin
			sync_req <= 1'h1;
			cmp_busy <= 1'h1;
		end
		@(posedge clk) sync_req <= 1'h0;
		repeat (4) begin
			@(posedge clk);
			#1;
			chk("sync held while busy", 1'h0, sd);
		end
		@(posedge clk) cmp_busy <= 1'h0;
		repeat (4) begin
			@(posedge clk);
			#1;
			hits += (sd === 1'h1);
		end
		chk("sync done pulses", 1, hits);
	endtask : sync_case
	initial begin
		#20000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		repeat (6) @(posedge clk);
		block_case();
		for (int c = 0; c < 3; c++)
			pause_case(c);
		sync_case();
		end_of_test();
	end
endmodule : testbench
